//--- logic/vcc_defines.svh
// Constants for the vector coordinate control block.
// Assumes inclusion by vcc_pkg and the design modules only.
`ifndef VCC_DEFINES_SVH
`define VCC_DEFINES_SVH

`define VCC_WORD_W 12
`define VCC_COORD_W 11
`define VCC_PARAM_W 9
`define VCC_EFF_LIMIT 11'sh200
`define VCC_VIS_X_LIMIT 11'sh100
`define VCC_VIS_Y_LIMIT 11'sh140
// Parameter word bit positions
`define VCC_PB_REL 0
`define VCC_PB_LONG 1
`define VCC_PB_INTENS 2
`define VCC_PB_IRESET 3
`define VCC_PB_ERASE 4
`define VCC_PB_FIG_LO 5
`define VCC_PB_FIG_HI 6
// Stroke times
`define VCC_CLK_MHZ 250
`define VCC_LONG_STROKE_US 4050
`define VCC_SHORT_STROKE_US 250
`define VCC_LONG_CYCLES (`VCC_LONG_STROKE_US * `VCC_CLK_MHZ)
`define VCC_SHORT_CYCLES (`VCC_SHORT_STROKE_US * `VCC_CLK_MHZ)

`endif

//--- logic/vcc_pkg.sv
// Types for the vector coordinate control block.
// Assumes the defines header sits beside it.
`include "vcc_defines.svh"

package vcc_pkg;
    typedef logic signed [`VCC_COORD_W-1:0] vcc_coord_t;
    typedef logic [`VCC_WORD_W-1:0] vcc_word_t;
    typedef logic [`VCC_PARAM_W-1:0] vcc_param_t;
    typedef enum logic [1:0] {
        VCC_FIG_LINE = 2'h0,
        VCC_FIG_POINT = 2'h1,
        VCC_FIG_CIRCLE = 2'h2,
        VCC_FIG_ARC = 2'h3
    } vcc_fig_e;
    typedef enum logic [3:0] {
        VCC_ST_WAIT_X = 4'h1,
        VCC_ST_WAIT_Y = 4'h2,
        VCC_ST_READY = 4'h4,
        VCC_ST_STROKE = 4'h8
    } vcc_state_e;
endpackage

//--- logic/vcc_stroke_timer.sv
// Stroke duration timer for the vector coordinate control block.
// Assumes a one-cycle start pulse and a clock at the VCC_CLK_MHZ rate of the defines header.
`include "vcc_defines.svh"

module vcc_stroke_timer #(
    parameter int LONG_CYCLES = `VCC_LONG_CYCLES,
    parameter int SHORT_CYCLES = `VCC_SHORT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic long_sel,
    output logic done
);
    import vcc_pkg::*;

    logic [23:0] count_reg;
    logic [23:0] count_next;
    logic done_reg;
    logic done_next;

    always_comb begin
        count_next = count_reg;
        done_next = 1'b0;
        if (start) begin
            count_next = long_sel ? 24'(LONG_CYCLES - 1) : 24'(SHORT_CYCLES - 1);
        end else if (count_reg != 24'h000000) begin
            count_next = count_reg - 24'h000001;
            done_next = (count_reg == 24'h000001);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count_reg <= 24'h000000;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
endmodule

//--- logic/vcc_top.sv
// Coordinate front end of a vector display controller.
// Assumes the host issues one-cycle write strobes with accumulator data.
//
// Behaviour
// - Coordinates live in a signed space spanning plus or minus 512 on both axes.
// - The visible window is plus or minus 256 in X and plus or minus 320 in Y.
// - An absolute coordinate is a displacement from the origin.
// - A relative coordinate adds to the last named position of that axis alone.
// - Figure characteristics arrive in a parameter word apart from coordinates.
// - X and Y positions arrive in data words apart from the parameter word.
// - Strokes resolve endpoints as absolute or relative per the mode bit.
// - Lines, points, circles and arcs are the four figure types.
// - Parameter and data words are taken as binary accumulator values.
// - Drawing options are single bits of a nine-bit parameter word.
// - Vector completion raises a ready flag for the host skip test.
// - An integrator reset returns the current position to the origin.
`include "vcc_defines.svh"

module vcc_top (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic param_wr,
    input wire logic data_wr,
    input wire vcc_pkg::vcc_word_t acc_data,
    input wire logic skip_clr,
    output logic ready_flag,
    output logic busy,
    output vcc_pkg::vcc_coord_t pos_x,
    output vcc_pkg::vcc_coord_t pos_y,
    output vcc_pkg::vcc_coord_t end_x,
    output vcc_pkg::vcc_coord_t end_y,
    output vcc_pkg::vcc_fig_e figure,
    output logic intensify,
    output logic long_stroke,
    output logic erase,
    output logic stroke_start,
    output logic visible
);
    import vcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Narrows an accumulator word to a coordinate; upper bits are sign extension
    function automatic vcc_coord_t to_coord(input vcc_word_t w);
        to_coord = w[`VCC_COORD_W-1:0];
    endfunction

    // Resolves one axis endpoint; wraps in the 11-bit coordinate width on overflow
    function automatic vcc_coord_t resolve(input logic rel, input vcc_coord_t base,
                                           input vcc_coord_t d);
        resolve = rel ? vcc_coord_t'(base + d) : d;
    endfunction

    function automatic logic in_window(input vcc_coord_t x, input vcc_coord_t y);
        in_window = (x >= -`VCC_VIS_X_LIMIT) && (x <= `VCC_VIS_X_LIMIT)
                 && (y >= -`VCC_VIS_Y_LIMIT) && (y <= `VCC_VIS_Y_LIMIT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    vcc_state_e state_reg, state_next;
    vcc_param_t param_reg, param_next;
    vcc_coord_t dx_reg, dx_next, dy_reg, dy_next;
    vcc_coord_t pos_x_reg, pos_x_next, pos_y_reg, pos_y_next;
    vcc_coord_t end_x_reg, end_x_next, end_y_reg, end_y_next;
    logic ready_reg, ready_next;
    logic start_reg, start_next;
    logic erase_reg, erase_next;
    logic vis_reg, vis_next;
    logic timer_done;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing

    always_comb begin
        state_next = state_reg;
        param_next = param_reg;
        dx_next = dx_reg;
        dy_next = dy_reg;
        pos_x_next = pos_x_reg;
        pos_y_next = pos_y_reg;
        end_x_next = end_x_reg;
        end_y_next = end_y_reg;
        ready_next = ready_reg;
        start_next = 1'b0;
        erase_next = 1'b0;
        vis_next = vis_reg;
        if (skip_clr) begin
            ready_next = 1'b0;
        end
        case (state_reg)
            VCC_ST_WAIT_X: begin
                if (data_wr) begin
                    dx_next = to_coord(acc_data);
                    state_next = VCC_ST_WAIT_Y;
                end
            end
            VCC_ST_WAIT_Y: begin
                if (data_wr) begin
                    dy_next = to_coord(acc_data);
                    state_next = VCC_ST_READY;
                end
            end
            VCC_ST_READY: begin
                if (data_wr) begin
                    // A fresh X restarts the coordinate pair
                    dx_next = to_coord(acc_data);
                    state_next = VCC_ST_WAIT_Y;
                end else if (param_wr) begin
                    param_next = acc_data[`VCC_PARAM_W-1:0];
                    erase_next = acc_data[`VCC_PB_ERASE];
                    if (acc_data[`VCC_PB_IRESET]) begin
                        // Origin reference taken before resolving relative endpoints
                        end_x_next = resolve(acc_data[`VCC_PB_REL], 11'sh000, dx_reg);
                        end_y_next = resolve(acc_data[`VCC_PB_REL], 11'sh000, dy_reg);
                        pos_x_next = 11'sh000;
                        pos_y_next = 11'sh000;
                    end else begin
                        end_x_next = resolve(acc_data[`VCC_PB_REL], pos_x_reg, dx_reg);
                        end_y_next = resolve(acc_data[`VCC_PB_REL], pos_y_reg, dy_reg);
                    end
                    ready_next = 1'b0;
                    start_next = 1'b1;
                    state_next = VCC_ST_STROKE;
                end
            end
            VCC_ST_STROKE: begin
                if (timer_done) begin
                    pos_x_next = end_x_reg;
                    pos_y_next = end_y_reg;
                    vis_next = in_window(end_x_reg, end_y_reg);
                    ready_next = 1'b1;
                    state_next = VCC_ST_WAIT_X;
                end
            end
            default: state_next = VCC_ST_WAIT_X;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg <= VCC_ST_WAIT_X;
            param_reg <= 9'h000;
            dx_reg <= 11'sh000;
            dy_reg <= 11'sh000;
            pos_x_reg <= 11'sh000;
            pos_y_reg <= 11'sh000;
            end_x_reg <= 11'sh000;
            end_y_reg <= 11'sh000;
            ready_reg <= 1'b0;
            start_reg <= 1'b0;
            erase_reg <= 1'b0;
            vis_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            param_reg <= param_next;
            dx_reg <= dx_next;
            dy_reg <= dy_next;
            pos_x_reg <= pos_x_next;
            pos_y_reg <= pos_y_next;
            end_x_reg <= end_x_next;
            end_y_reg <= end_y_next;
            ready_reg <= ready_next;
            start_reg <= start_next;
            erase_reg <= erase_next;
            vis_reg <= vis_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stroke duration; points, circles and arcs share the line timer as the analog side sets shape

    vcc_stroke_timer u_timer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(start_reg),
        .long_sel(param_reg[`VCC_PB_LONG]),
        .done(timer_done)
    );

    assign ready_flag = ready_reg;
    assign busy = state_reg[3];
    assign pos_x = pos_x_reg;
    assign pos_y = pos_y_reg;
    assign end_x = end_x_reg;
    assign end_y = end_y_reg;
    assign figure = vcc_fig_e'(param_reg[`VCC_PB_FIG_HI:`VCC_PB_FIG_LO]);
    assign intensify = param_reg[`VCC_PB_INTENS];
    assign long_stroke = param_reg[`VCC_PB_LONG];
    assign erase = erase_reg;
    assign stroke_start = start_reg;
    assign visible = vis_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    abs_endpoint_a: assert property (param_wr && state_reg == VCC_ST_READY
        && !acc_data[`VCC_PB_REL] |=> end_x == $past(dx_reg) && end_y == $past(dy_reg))
        else $error("absolute endpoint wrong");
    rel_endpoint_a: assert property (param_wr && state_reg == VCC_ST_READY
        && acc_data[`VCC_PB_REL] && !acc_data[`VCC_PB_IRESET]
        |=> end_x == vcc_coord_t'($past(pos_x_reg) + $past(dx_reg)))
        else $error("relative endpoint wrong");
    ireset_origin_a: assert property (param_wr && state_reg == VCC_ST_READY
        && acc_data[`VCC_PB_IRESET] |=> pos_x == 11'sh000 && pos_y == 11'sh000)
        else $error("integrator reset missed origin");
    ready_done_a: assert property (state_reg == VCC_ST_STROKE && timer_done
        |=> ready_flag && state_reg == VCC_ST_WAIT_X)
        else $error("ready flag not raised");
    start_pulse_a: assert property (stroke_start |=> !stroke_start && busy)
        else $error("stroke start not one cycle");
    x_then_y_a: assert property (state_reg == VCC_ST_WAIT_X && data_wr
        |=> state_reg == VCC_ST_WAIT_Y)
        else $error("x word not followed by y");
    param_latch_a: assert property (param_wr && state_reg == VCC_ST_READY
        |=> param_reg == $past(acc_data[`VCC_PARAM_W-1:0]))
        else $error("parameter word not latched");
    ready_clear_a: assert property (stroke_start |-> !ready_flag)
        else $error("ready held during stroke");
    range_a: assert property (pos_x >= -`VCC_EFF_LIMIT && pos_x < `VCC_EFF_LIMIT)
        else $error("x outside effective range");
    pos_hold_a: assert property (busy && !timer_done |=> $stable(pos_x))
        else $error("position moved mid stroke");

    cov_abs_c: cover property (stroke_start && !param_reg[`VCC_PB_REL]);
    cov_rel_c: cover property (stroke_start && param_reg[`VCC_PB_REL]);
    cov_done_c: cover property (timer_done);
    cov_offscreen_c: cover property (ready_flag && !visible);
endmodule

//--- verification/vcc_host_model.sv
// Host model: programmed I/O writes of accumulator words into the block.
// Assumes the bench runs clk_sys and calls these tasks from one process.
module vcc_host_model (
    input wire logic clk_sys,
    output logic param_wr,
    output logic data_wr,
    output vcc_pkg::vcc_word_t acc_data,
    output logic skip_clr
);
    timeunit 1ns;
    timeprecision 100ps;
    import vcc_pkg::*;

    initial begin
        param_wr = 1'b0;
        data_wr = 1'b0;
        skip_clr = 1'b0;
        acc_data = 12'h000;
    end

    // Released bus shows the inverse of the last word, so a stale sample cannot pass
    task automatic send(input logic is_param, input vcc_word_t word);
        @(posedge clk_sys);
        acc_data <= word;
        param_wr <= is_param;
        data_wr <= !is_param;
        @(posedge clk_sys);
        param_wr <= 1'b0;
        data_wr <= 1'b0;
        acc_data <= ~word;
    endtask

    task automatic put_data(input vcc_coord_t c);
        send(1'b0, {c[10], c});
    endtask

    task automatic put_param(input vcc_param_t p);
        send(1'b1, {3'h0, p});
    endtask

    task automatic put_point(input vcc_coord_t x, input vcc_coord_t y, input vcc_param_t p);
        put_data(x);
        put_data(y);
        put_param(p);
    endtask

    task automatic clear_skip;
        @(posedge clk_sys);
        skip_clr <= 1'b1;
        @(posedge clk_sys);
        skip_clr <= 1'b0;
    endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the coordinate front end.
// Assumes the stroke timer keeps its own counts; only one short stroke is run to the end.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vcc_pkg::*;

    typedef struct {
        vcc_coord_t x;
        vcc_coord_t y;
        vcc_param_t prm;
        vcc_coord_t ex;
        vcc_coord_t ey;
        vcc_fig_e fig;
    } vcc_row_s;

    logic clk_sys;
    logic reset_n;
    logic param_wr, data_wr, skip_clr;
    vcc_word_t acc_data;
    logic ready_flag, busy, intensify, long_stroke, erase, stroke_start, visible;
    vcc_coord_t pos_x, pos_y, end_x, end_y;
    vcc_fig_e figure;
    int errors = 0;
    int samples_checked = 0;
    vcc_row_s rows[4];

    vcc_top vcc_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .param_wr(param_wr),
        .data_wr(data_wr), .acc_data(acc_data), .skip_clr(skip_clr), .ready_flag(ready_flag),
        .busy(busy), .pos_x(pos_x), .pos_y(pos_y), .end_x(end_x), .end_y(end_y),
        .figure(figure), .intensify(intensify), .long_stroke(long_stroke), .erase(erase),
        .stroke_start(stroke_start), .visible(visible));

    vcc_host_model vcc_host_model_i (.clk_sys(clk_sys), .param_wr(param_wr),
        .data_wr(data_wr), .acc_data(acc_data), .skip_clr(skip_clr));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_coord(input string name, input vcc_coord_t exp, input vcc_coord_t got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic chk_flag(input string name, input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic do_reset(input int n);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        reset_n <= 1'b1;
    endtask

    // Outputs land on the edge that takes the parameter word, where put_param returns;
    // one more edge would already have dropped the one-cycle start pulse
    task automatic chk_start(input vcc_coord_t ex, input vcc_coord_t ey);
        #1;
        chk_flag("stroke_start", 2'h1, {1'b0, stroke_start});
        chk_flag("busy", 2'h1, {1'b0, busy});
        chk_coord("end_x", ex, end_x);
        chk_coord("end_y", ey, end_y);
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        while (ready_flag !== 1'b1 && n < 63000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk_flag("ready_flag", 2'h1, {1'b0, ready_flag});
        if (ready_flag !== 1'b1) begin
            wrap_up();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        rows[0] = '{11'sd85, 11'sd255, 9'h006, 11'sd85, 11'sd255, VCC_FIG_LINE};
        rows[1] = '{-11'sd256, 11'sd320, 9'h024, -11'sd256, 11'sd320, VCC_FIG_POINT};
        rows[2] = '{-11'sd512, 11'sd511, 9'h041, -11'sd512, 11'sd511, VCC_FIG_CIRCLE};
        rows[3] = '{11'sd170, -11'sd170, 9'h079, 11'sd170, -11'sd170, VCC_FIG_ARC};
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_flag("ready_flag", 2'h0, {1'b0, ready_flag});
        chk_flag("visible", 2'h1, {1'b0, visible});
        chk_coord("pos_x", 11'sd0, pos_x);
        $display("test reset done");
        // Each row aborts its stroke by reset, so relative rows start from the origin
        foreach (rows[i]) begin
            do_reset(2);
            vcc_host_model_i.put_point(rows[i].x, rows[i].y, rows[i].prm);
            chk_start(rows[i].ex, rows[i].ey);
            chk_flag("figure", rows[i].fig, figure);
            chk_flag("intensify", {1'b0, rows[i].prm[2]}, {1'b0, intensify});
            chk_flag("long_stroke", {1'b0, rows[i].prm[1]}, {1'b0, long_stroke});
            chk_flag("erase", {1'b0, rows[i].prm[4]}, {1'b0, erase});
            $display("test row %0d done", i);
        end
        // Parameter word before Y must be refused
        do_reset(2);
        vcc_host_model_i.put_data(11'sd500);
        vcc_host_model_i.put_param(9'h000);
        repeat (3) @(posedge clk_sys);
        #1;
        chk_flag("stroke_start", 2'h0, {1'b0, stroke_start});
        vcc_host_model_i.put_data(-11'sd300);
        vcc_host_model_i.put_param(9'h000);
        chk_start(11'sd500, -11'sd300);
        vcc_host_model_i.put_data(11'sd7);
        chk_coord("end_x", 11'sd500, end_x);
        $display("test refused order done");
        wait_ready();
        chk_flag("busy", 2'h0, {1'b0, busy});
        chk_coord("pos_x", 11'sd500, pos_x);
        chk_coord("pos_y", -11'sd300, pos_y);
        chk_flag("visible", 2'h0, {1'b0, visible});
        vcc_host_model_i.clear_skip();
        #1;
        chk_flag("ready_flag", 2'h0, {1'b0, ready_flag});
        $display("test completed stroke done");
        // Relative sum wraps in the coordinate width
        vcc_host_model_i.put_point(11'sd600, -11'sd100, 9'h001);
        // 500 + 600 wraps in 11 bits to 1100 - 2048
        chk_start(-11'sd948, -11'sd400);
        $display("test relative done");
        wrap_up();
    end
endmodule
